// ### core/rcs_cmp_unit.sv
// Equality compare of accumulator against a memory word
`timescale 1ns/10ps
module rcs_cmp_unit (
	// Operands
	input wire logic [rcs_pkg::WORD_W-1:0] acc,
	input wire logic [rcs_pkg::WORD_W-1:0] word,
	// Result
	output logic equal
);
	import rcs_pkg::*;
	// Zero indicator source
	assign equal = (acc == word);
endmodule : rcs_cmp_unit

// ### core/rcs_seq.sv
// Repeat sequencer with table compare and index setup operations
`timescale 1ns/10ps
module rcs_seq (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Operation request
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic [rcs_pkg::HALF_W-1:0] op_addr,
	input wire logic [rcs_pkg::CNT_W-1:0] op_count,
	input wire logic [rcs_pkg::HALF_W-1:0] op_step,
	input wire logic op_fix_idx1,
	output logic op_ready,
	// Register loads from software
	input wire logic acc_load,
	input wire logic [rcs_pkg::WORD_W-1:0] acc_in,
	input wire logic q_load,
	input wire logic [rcs_pkg::WORD_W-1:0] q_in,
	input wire logic idx1_load,
	input wire logic [rcs_pkg::HALF_W-1:0] idx1_in,
	// Memory read port
	output logic mem_rd,
	output logic [rcs_pkg::HALF_W-1:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [rcs_pkg::WORD_W-1:0] mem_data,
	// State
	output logic [rcs_pkg::HALF_W-1:0] idx0,
	output logic [rcs_pkg::HALF_W-1:0] idx1,
	output logic [rcs_pkg::WORD_W-1:0] q_reg,
	output logic zero_flag,
	output logic neg_flag,
	output logic rpt_busy
);
	import rcs_pkg::*;

	rcs_state_t state_q, state_d;
	logic [HALF_W-1:0] idx0_q, idx0_d, idx1_q, idx1_d, step_q, step_d;
	logic [WORD_W-1:0] acc_q, acc_d, q_q, q_d, data_q, data_d;
	logic [8:0] left_q, left_d;
	logic cmp_q, cmp_d, stopz_q, stopz_d, fixsel_q, fixsel_d;
	logic zero_q, zero_d, neg_q, neg_d;
	logic equal;
	logic [CNT_W-1:0] cnt_field;
	logic [8:0] left_now;

	rcs_cmp_unit u_cmp (
		.acc(acc_q),
		.word(data_q),
		.equal(equal)
	);

	assign cnt_field = idx0_q[CNT_W-1+CNT_LSB:CNT_LSB];
	assign op_ready = (state_q == RCS_IDLE);
	assign mem_rd = (state_q == RCS_FETCH);
	assign mem_addr = idx1_q;
	assign idx0 = idx0_q;
	assign idx1 = idx1_q;
	assign q_reg = q_q;
	assign zero_flag = zero_q;
	assign neg_flag = neg_q;
	assign rpt_busy = (state_q != RCS_IDLE);

	// Next state of sequencer and registers
	always_comb begin
		state_d = state_q;
		idx0_d = idx0_q;
		idx1_d = idx1_q;
		step_d = step_q;
		acc_d = acc_load ? acc_in : acc_q;
		q_d = q_load ? q_in : q_q;
		data_d = data_q;
		left_d = left_q;
		cmp_d = cmp_q;
		stopz_d = stopz_q;
		fixsel_d = fixsel_q;
		zero_d = zero_q;
		neg_d = neg_q;
		left_now = 9'h000;
		if (idx1_load && state_q == RCS_IDLE) begin
			idx1_d = idx1_in;
		end
		case (state_q)
			RCS_IDLE: begin
				if (op_valid) begin
					if (op_code == OP_RPT_IDX) begin
						left_d = (cnt_field == 8'h00) ? CNT_FULL : {1'b0, cnt_field};
						stopz_d = idx0_q[TZE_BIT];
						step_d = op_step;
						cmp_d = 1'b1;
						state_d = RCS_FETCH;
					end else if (op_code == OP_RPT_FIX) begin
						left_d = (op_count == 8'h00) ? CNT_FULL : {1'b0, op_count};
						step_d = op_step;
						fixsel_d = op_fix_idx1;
						stopz_d = 1'b0;
						cmp_d = 1'b0;
						state_d = RCS_CMP;
					end else if (op_code == OP_EA_IDX0) begin
						idx0_d = q_d[HALF_W-1:0] + op_addr;
					end else if (op_code == OP_SUB_Q) begin
						q_d = q_q - UNIT_B25;
						zero_d = (q_d == 36'h000000000);
						neg_d = q_d[WORD_W-1];
					end else if (op_code == OP_CMP) begin
						// single word fetch
						// Word is read at index 1 through the port, never from an idle bus
						cmp_d = 1'b1;
						left_d = 9'h000;
						state_d = RCS_FETCH;
					end
				end
			end
			RCS_FETCH: begin
				if (mem_ack) begin
					data_d = mem_data;
					state_d = RCS_CMP;
				end
			end
			RCS_CMP: begin
				if (cmp_d) begin
					zero_d = equal;
				end
				if (left_q != 9'h000) begin
					left_now = left_q - 9'h001;
					left_d = left_now;
					idx0_d[CNT_W-1+CNT_LSB:CNT_LSB] = left_now[CNT_W-1:0];
					if (cmp_q || fixsel_q) begin
						idx1_d = idx1_q + step_q;
					end else begin
						idx0_d = idx0_d + step_q;
					end
				end
				if ((stopz_q && cmp_q && equal) || left_now == 9'h000) begin
					state_d = RCS_IDLE;
				end else begin
					state_d = cmp_q ? RCS_FETCH : RCS_CMP;
				end
			end
			default: begin
				state_d = RCS_IDLE;
			end
		endcase
	end

	// Register update
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_q <= RCS_IDLE;
			idx0_q <= IDX_RST;
			idx1_q <= IDX_RST;
			step_q <= IDX_RST;
			acc_q <= 36'h000000000;
			q_q <= 36'h000000000;
			data_q <= 36'h000000000;
			left_q <= 9'h000;
			cmp_q <= 1'b0;
			stopz_q <= 1'b0;
			fixsel_q <= 1'b0;
			zero_q <= 1'b0;
			neg_q <= 1'b0;
		end else begin
			state_q <= state_d;
			idx0_q <= idx0_d;
			idx1_q <= idx1_d;
			step_q <= step_d;
			acc_q <= acc_d;
			q_q <= q_d;
			data_q <= data_d;
			left_q <= left_d;
			cmp_q <= cmp_d;
			stopz_q <= stopz_d;
			fixsel_q <= fixsel_d;
			zero_q <= zero_d;
			neg_q <= neg_d;
		end
	end

	// Checks
	a_zero_on_equal: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_CMP && cmp_q) |=> (zero_q == $past(equal))) else $error("zero flag not compare result");
	a_step_idx1: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_CMP && cmp_q && left_q != 9'h000) |=> (idx1_q == $past(idx1_q) + $past(step_q)))
		else $error("index 1 not stepped");
	a_count_dec: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_CMP && left_q != 9'h000) |=> (left_q == $past(left_q) - 9'h001)) else $error("count not decremented");
	a_zero_is_256: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_IDLE && op_valid && op_code == OP_RPT_IDX && cnt_field == 8'h00) |=> (left_q == CNT_FULL))
		else $error("zero count not 256");
	a_count_start: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_IDLE && op_valid && op_code == OP_RPT_IDX && cnt_field != 8'h00) |=> (left_q[7:0] == $past(cnt_field)))
		else $error("count not sampled");
	a_match_stop: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_CMP && cmp_q && stopz_q && equal) |=> (state_q == RCS_IDLE)) else $error("no stop on match");
	a_exhaust_zero: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_CMP && left_q == 9'h001) |=> (state_q == RCS_IDLE && idx0_q[17:10] == 8'h00))
		else $error("count field not zero");
	a_stop_bit: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_IDLE && op_valid && op_code == OP_RPT_IDX) |=> (stopz_q == $past(idx0_q[TZE_BIT])))
		else $error("stop enable wrong");
	a_ea_load: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_IDLE && op_valid && op_code == OP_EA_IDX0 && !q_load) |=> (idx0_q == $past(q_q[17:0]) + $past(op_addr)))
		else $error("index 0 load wrong");
	a_sub_unit: assert property (@(posedge ref_clk) disable iff (rst)
		(state_q == RCS_IDLE && op_valid && op_code == OP_SUB_Q && !q_load) |=> (q_q == $past(q_q) - UNIT_B25))
		else $error("quotient subtract wrong");
	c_match: cover property (@(posedge ref_clk) state_q == RCS_CMP && cmp_q && equal && stopz_q);
	c_exhaust: cover property (@(posedge ref_clk) state_q == RCS_CMP && left_q == 9'h001);
	c_fixed: cover property (@(posedge ref_clk) state_q == RCS_CMP && !cmp_q);
endmodule : rcs_seq

// ### pkg/rcs_pkg.sv
// Constants and types for the repeat compare sequencer
package rcs_pkg;
	localparam int WORD_W = 36;
	localparam int HALF_W = 18;
	localparam int CNT_W = 8;
	localparam int CNT_LSB = 10;            // Count field is index bits 0-7 (MSB-first numbering)
	localparam int TZE_BIT = 6;             // Weight 64 enables stop on zero indicator
	localparam logic [8:0] CNT_FULL = 9'h100;
	localparam logic [HALF_W-1:0] IDX_RST = 18'h00000;
	localparam logic [WORD_W-1:0] UNIT_B25 = 36'h000000400; // One unit at binary point 25
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_RPT_IDX = 4'h1;
	localparam logic [3:0] OP_RPT_FIX = 4'h2;
	localparam logic [3:0] OP_EA_IDX0 = 4'h3;
	localparam logic [3:0] OP_SUB_Q = 4'h4;
	localparam logic [3:0] OP_CMP = 4'h5;
	typedef enum logic [2:0] {
		RCS_IDLE = 3'b001,
		RCS_FETCH = 3'b010,
		RCS_CMP = 3'b100
	} rcs_state_t;
endpackage : rcs_pkg

// ### tb/rcs_mem_model.sv
// Table memory answering reads after a chosen wait
`timescale 1ns/10ps
module rcs_mem_model (
	// Clock, reset and wait
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [1:0] lat,
	// Read port
	input wire logic mem_rd,
	input wire logic [17:0] mem_addr,
	output logic mem_ack,
	output logic [35:0] mem_data
);
	logic [1:0] wait_q;
	// Word is tag plus address; idle data toggles
	always_ff @(posedge ref_clk) begin
		if (rst || !mem_rd || mem_ack) wait_q <= 2'h0;
		else if (wait_q != lat) wait_q <= wait_q + 2'h1;
		mem_ack <= !rst && mem_rd && !mem_ack && wait_q == lat;
		mem_data <= rst ? 36'h0 : (mem_rd && !mem_ack && wait_q == lat) ? {18'h2a5a5, mem_addr} : ~mem_data;
	end
endmodule : rcs_mem_model

// ### tb/rcs_seq_bench.sv
// Bench for the repeat compare sequencer
`timescale 1ns/10ps
module rcs_seq_bench;
	import rcs_pkg::*;
	logic ref_clk = 0, rst = 1, op_valid = 0, op_fix_idx1 = 0, acc_load = 0, q_load = 0, idx1_load = 0;
	logic [3:0] op_code = 0;
	logic [17:0] op_addr = 0, op_step = 0, idx1_in = 0, mem_addr, idx0, idx1;
	logic [7:0] op_count = 0;
	logic [35:0] acc_in = 0, q_in = 0, mem_data, q_reg;
	logic [1:0] lat = 0;
	logic op_ready, mem_rd, mem_ack, zero_flag, neg_flag, rpt_busy;
	int num_errors = 0, compares = 0;
	rcs_seq u_dut (.ref_clk, .rst, .op_valid, .op_code, .op_addr, .op_count, .op_step, .op_fix_idx1,
		.op_ready, .acc_load, .acc_in, .q_load, .q_in, .idx1_load, .idx1_in, .mem_rd, .mem_addr,
		.mem_ack, .mem_data, .idx0, .idx1, .q_reg, .zero_flag, .neg_flag, .rpt_busy);
	rcs_mem_model u_mem (.ref_clk, .rst, .lat, .mem_rd, .mem_addr, .mem_ack, .mem_data);
	// Clock of 4 ns
	always #2 ref_clk = ~ref_clk;
	task chk(input logic [35:0] seen, input logic [35:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Issue one operation and wait until idle
	task run(input logic [3:0] c, input logic [17:0] a, input logic [7:0] k, input logic [17:0] w, input logic f);
		@(posedge ref_clk);
		op_valid <= 1'b1;
		op_code <= c;
		op_addr <= a;
		op_count <= k;
		op_step <= w;
		op_fix_idx1 <= f;
		@(posedge ref_clk);
		op_valid <= 1'b0;
		#1;
		chk(op_ready, (c == OP_RPT_IDX || c == OP_RPT_FIX || c == OP_CMP) ? 1'b0 : 1'b1); // busy until sequence ends
		while (rpt_busy !== 1'b0) begin
			@(posedge ref_clk);
			#1;
		end
	endtask : run
	// Load accumulator, quotient and index 1 together
	task ld(input logic [35:0] a, input logic [35:0] q, input logic [17:0] x);
		@(posedge ref_clk);
		{acc_load, q_load, idx1_load} <= 3'h7;
		acc_in <= a;
		q_in <= q;
		idx1_in <= x;
		@(posedge ref_clk);
		{acc_load, q_load, idx1_load} <= 3'h0;
	endtask : ld
	// Size counted down past empty, then index setup and one unit off
	task s_setup();
		ld(36'h0, 36'h400, 18'h100);
		run(OP_SUB_Q, 18'h0, 8'h0, 18'h0, 1'b0);
		chk(zero_flag, 1'b1); // last unit removed
		run(OP_SUB_Q, 18'h0, 8'h0, 18'h0, 1'b0);
		chk(q_reg, 36'hffffffc00); // empty size borrows
		chk(neg_flag, 1'b1); // borrow shows negative
		ld(36'h0, 36'hc00, 18'h100);
		run(OP_EA_IDX0, 18'h40, 8'h0, 18'h0, 1'b0);
		chk(idx0, 36'hc40); // quotient plus address
		run(OP_SUB_Q, 18'h0, 8'h0, 18'h0, 1'b0);
		chk(q_reg, 36'h800); // one unit removed
		chk(neg_flag, 1'b0); // size still positive
	endtask : s_setup
	// Three passes without a hit, then 256 slow passes
	task s_exhaust();
		run(OP_RPT_IDX, 18'h0, 8'h0, 18'h2, 1'b0);
		chk(idx1, 36'h106); // step per pass
		chk(idx0, 36'h40); // count left zero
		chk(zero_flag, 1'b0); // no hit clears
		lat <= 2'h3;
		run(OP_RPT_IDX, 18'h0, 8'h0, 18'h2, 1'b0);
		chk(idx1, 36'h306); // zero count runs 256
		lat <= 2'h0;
	endtask : s_exhaust
	// Hit on third pass with stop enabled
	task s_match();
		ld({18'h2a5a5, 18'h104}, 36'h0, 18'h100);
		run(OP_EA_IDX0, 18'h40, 8'h0, 18'h0, 1'b0);
		run(OP_RPT_IDX, 18'h0, 8'h0, 18'h2, 1'b0);
		chk(zero_flag, 1'b1); // hit sets flag
		chk(idx1, 36'h106); // hit address plus step
		chk(idx0, 36'h3f440); // count down by three
	endtask : s_match
	// Hit ignored without stop enable
	task s_nostop();
		ld({18'h2a5a5, 18'h104}, 36'h800, 18'h104);
		run(OP_EA_IDX0, 18'h0, 8'h0, 18'h0, 1'b0);
		run(OP_RPT_IDX, 18'h0, 8'h0, 18'h1, 1'b0);
		chk(idx1, 36'h106); // runs past the hit
		chk(idx0, 36'h0); // stops on count end
		chk(zero_flag, 1'b0); // last pass result
	endtask : s_nostop
	// Fixed count repeats stepping index 1, then index 0
	task s_fixed();
		run(OP_RPT_FIX, 18'h0, 8'h5, 18'h3, 1'b1);
		chk(idx1, 36'h115); // five steps of three
		run(OP_RPT_FIX, 18'h0, 8'h0, 18'h1, 1'b1);
		chk(idx1, 36'h215); // zero count runs 256
		run(OP_RPT_FIX, 18'h0, 8'h2, 18'h1, 1'b0);
		chk(idx0, 36'h2); // two steps on index 0
		chk(idx1, 36'h215); // index 1 left alone
	endtask : s_fixed
	// Single compare, hit then miss, no stepping
	task s_single();
		ld({18'h2a5a5, 18'h120}, 36'h0, 18'h120);
		run(OP_CMP, 18'h0, 8'h0, 18'h0, 1'b0);
		chk(zero_flag, 1'b1); // single hit sets flag
		chk(idx1, 36'h120); // single compare no step
		ld({18'h2a5a5, 18'h120}, 36'h0, 18'h121);
		run(OP_CMP, 18'h0, 8'h0, 18'h0, 1'b0);
		chk(zero_flag, 1'b0); // single miss clears flag
	endtask : s_single
	task test_done();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	// Main sequence after reset
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		s_setup();
		s_exhaust();
		s_match();
		s_nostop();
		s_fixed();
		s_single();
		test_done();
	end
	// Watchdog against a hang
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
endmodule : rcs_seq_bench
